// >>> csc_ctrl.sv
// Clock source selection, sleep control and reset collection for the whole chip.
// Assumes the oscillators, CPU and peripherals outside; pins are asynchronous.
//
// Decided for this implementation: the plain strobed port and the address map.
`default_nettype none
module csc_ctrl #(
	parameter logic [16:0] BOOT_VEC = 17'h10000 // Boot section start address.
) (
	input wire logic clk, // System clock.
	input wire logic rst_b, // Power-on reset, active low.
	input wire logic ext_rst_pin_b, // External reset pin, active low.
	input wire logic wdt_rst, // Watchdog reset request.
	input wire logic bod_rst, // Brown-out reset request.
	input wire logic pdi_rst, // Debug interface reset request.
	input wire logic [3:0] addr, // Register address.
	input wire logic [7:0] wdata, // Write data.
	input wire logic we, // Write strobe.
	input wire logic re, // Read strobe.
	output logic [7:0] rdata, // Read data, cycle after re.
	input wire logic [4:0] osc_ready, // Oscillator ready levels.
	input wire logic xosc_ok, // Crystal running level.
	input wire csc_pkg::csc_wake_t wake_in, // Wake requests.
	input wire logic rtc_en, // Real-time counter enabled.
	input wire logic sleep_instr, // Halt-entry instruction pulse.
	input wire logic boot_fuse, // Boot vector relocation strap.
	output logic [2:0] sys_src_r, // Active system clock source.
	output logic [3:0] presc_code_r, // Prescaler exponent.
	output logic [4:0] pll_mult_r, // Multiplication factor.
	output logic [1:0] pll_in_r, // Multiplier input.
	output logic [1:0] xosc_kind_r, // Crystal/external clock kind.
	output logic [1:0] rtc_src_r, // Real-time counter clock.
	output logic [4:0] osc_run_r, // Oscillator run enables.
	output logic [2:0] cal_r, // 2M trim, 32M trim, reference.
	output logic nmi_r, // Crystal failure pulse.
	output csc_pkg::csc_gate_t gate_r, // Domain clock enables.
	output logic [7:0] per_clk_en_r, // Peripheral clock enables.
	output logic cpu_halt_r, // CPU halted.
	output logic resume_r, // Wake pulse to CPU.
	output logic io_hiz_r, // Pins high-impedance.
	output logic reset_out_b, // Chip reset, active low.
	output logic [16:0] reset_vec_r // Reset vector address.
);
	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} csc_state_t;

	logic raw_rst_b;
	logic [1:0] rst_sync_r;
	logic sw_rst_r;
	logic [5:0] cause_s1_r, cause_s2_r;
	logic [5:0] rstat_r;
	logic [4:0] rdy_s1_r, rdy_s2_r;
	logic xok_s1_r, xok_s2_r, xok_d_r;
	logic [3:0] wk_s1_r, wk_s2_r;
	logic boot_s1_r, boot_s2_r;
	logic [2:0] sel_req_r;
	logic [4:0] osc_en_r;
	logic fail_en_r, fail_flag_r, fail_det;
	logic [3:0] slp_r;
	logic [7:0] pr_r;
	logic [2:0] prot_cnt_r;
	logic [2:0] mode_r;
	logic [1:0] wcnt_r;
	csc_state_t st_r, st_nxt;
	csc_pkg::csc_gate_t gate_nxt;
	logic wr_fail, sw_req;
	logic [2:0] gate_mode;

	// Legal sleep mode codes.
	function automatic logic mode_ok(input logic [2:0] m);
		mode_ok = (m == csc_pkg::SM_IDLE) || (m == csc_pkg::SM_PDOWN) ||
			(m == csc_pkg::SM_PSAVE) || (m == csc_pkg::SM_STDBY) || (m == csc_pkg::SM_ESTDBY);
	endfunction

	// Wake sources allowed in each mode.
	function automatic logic wake_ok(input logic [2:0] m, input logic [3:0] w, input logic rtc);
		csc_pkg::csc_wake_t x;
		x = w;
		wake_ok = x.port_async | x.twi_match;
		if (m == csc_pkg::SM_IDLE) begin
			wake_ok = wake_ok | x.irq_any | x.rtc_irq;
		end
		if ((m == csc_pkg::SM_PSAVE) || (m == csc_pkg::SM_ESTDBY)) begin
			wake_ok = wake_ok | (x.rtc_irq & rtc);
		end
	endfunction

	// Clock enables while asleep in a mode.
	function automatic csc_pkg::csc_gate_t sleep_gate(input logic asleep, input logic [2:0] m,
		input logic rtc);
		csc_pkg::csc_gate_t g;
		g = '1;
		if (asleep) begin
			g = '0;
			unique case (m)
				csc_pkg::SM_IDLE: g = '{cpu: 1'b0, nvm: 1'b0, default: 1'b1};
				csc_pkg::SM_PDOWN: g = '0;
				csc_pkg::SM_PSAVE: g.rtc = rtc;
				csc_pkg::SM_STDBY: g.osc = 1'b1;
				csc_pkg::SM_ESTDBY: begin
					g.osc = 1'b1;
					g.rtc = rtc;
				end
				default: g = '1;
			endcase
		end
		return g;
	endfunction

	// Any pin reset source pulls the chip into reset with no clock needed; software reset first needs an edge to set sw_rst_r.
	assign raw_rst_b = rst_b & ext_rst_pin_b & ~wdt_rst & ~bod_rst & ~pdi_rst & ~sw_rst_r;

	// Release is synchronised to the clock; entry stays asynchronous.
	always_ff @(posedge clk or negedge raw_rst_b) begin
		if (!raw_rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign reset_out_b = rst_sync_r[1];

	// Pins float from the moment a source is active until one cycle after release.
	always_ff @(posedge clk or negedge raw_rst_b) begin
		if (!raw_rst_b) begin
			io_hiz_r <= 1'b1;
		end else begin
			io_hiz_r <= ~rst_sync_r[1];
		end
	end

	// Software reset request; lives on power-on reset so it can end the reset it starts.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_rst_r <= 1'b0;
		end else if (sw_req) begin
			sw_rst_r <= 1'b1;
		end else if (!rst_sync_r[1]) begin
			sw_rst_r <= 1'b0;
		end
	end

	// Cause levels cross into the clock domain before recording.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cause_s1_r <= 6'h0;
			cause_s2_r <= 6'h0;
		end else begin
			cause_s1_r <= {1'b0, pdi_rst, bod_rst, wdt_rst, ~ext_rst_pin_b, 1'b0};
			cause_s2_r <= cause_s1_r;
		end
	end

	// Reset status survives every reset but power-on; a new cause beats a clear.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstat_r <= csc_pkg::RSTAT_POR;
		end else begin
			rstat_r <= (rstat_r & ~((we && addr == csc_pkg::A_RST_STAT) ? wdata[5:0] : 6'h0))
				| cause_s2_r | {sw_rst_r, 5'h0};
		end
	end

	// Two-stage synchronisers for oscillator, wake and strap levels.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			rdy_s1_r <= 5'h0;
			rdy_s2_r <= 5'h0;
			xok_s1_r <= 1'b0;
			xok_s2_r <= 1'b0;
			xok_d_r <= 1'b0;
			wk_s1_r <= 4'h0;
			wk_s2_r <= 4'h0;
			boot_s1_r <= 1'b0;
			boot_s2_r <= 1'b0;
		end else begin
			rdy_s1_r <= osc_ready;
			rdy_s2_r <= rdy_s1_r;
			xok_s1_r <= xosc_ok;
			xok_s2_r <= xok_s1_r;
			xok_d_r <= xok_s2_r;
			wk_s1_r <= wake_in;
			wk_s2_r <= wk_s1_r;
			boot_s1_r <= boot_fuse;
			boot_s2_r <= boot_s1_r;
		end
	end

	// Vector taken after release from the strap.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			reset_vec_r <= 17'h0;
		end else begin
			reset_vec_r <= boot_s2_r ? BOOT_VEC : 17'h0;
		end
	end

	// Crystal loss while it feeds the system clock.
	assign fail_det = fail_en_r && xok_d_r && !xok_s2_r &&
		(sys_src_r == csc_pkg::SRC_XOSC ||
		(sys_src_r == csc_pkg::SRC_PLL && pll_in_r == csc_pkg::PLL_IN_XOSC));
	assign wr_fail = we && addr == csc_pkg::A_FAIL;
	assign sw_req = we && addr == csc_pkg::A_SW_RST && wdata[0] && prot_cnt_r != 3'h0;

	// Source request and glitch-safe switch once the target is ready.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			sel_req_r <= csc_pkg::SRC_RC2M;
			sys_src_r <= csc_pkg::SRC_RC2M;
			xosc_kind_r <= 2'h0;
		end else if (fail_det) begin
			sel_req_r <= csc_pkg::SRC_RC2M;
			sys_src_r <= csc_pkg::SRC_RC2M;
		end else begin
			if (we && addr == csc_pkg::A_CLK_SEL) begin
				xosc_kind_r <= wdata[5:4];
				if (wdata[2:0] <= csc_pkg::SRC_PLL) begin
					sel_req_r <= wdata[2:0];
				end
			end
			if (rdy_s2_r[sel_req_r] && osc_en_r[sel_req_r]) begin
				sys_src_r <= sel_req_r;
			end
		end
	end

	// Prescaler, multiplier, real-time counter clock and calibrator settings.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			presc_code_r <= csc_pkg::PRESC_RST;
			pll_mult_r <= csc_pkg::PLL_RST;
			pll_in_r <= csc_pkg::PLL_IN_RC2M;
			rtc_src_r <= csc_pkg::RTC_ULP;
			cal_r <= 3'h0;
		end else if (we) begin
			if (addr == csc_pkg::A_PRESC && wdata[3:0] <= csc_pkg::PRESC_MAX) begin
				presc_code_r <= wdata[3:0];
			end
			if (addr == csc_pkg::A_PLL && wdata[4:0] >= csc_pkg::PLL_MIN
				&& wdata[6:5] <= csc_pkg::PLL_IN_XOSC) begin
				pll_mult_r <= wdata[4:0];
				pll_in_r <= wdata[6:5];
			end
			if (addr == csc_pkg::A_RTC_SEL && wdata[1:0] <= csc_pkg::RTC_XTAL32K) begin
				rtc_src_r <= wdata[1:0];
			end
			if (addr == csc_pkg::A_CAL) begin
				cal_r <= wdata[2:0];
			end
		end
	end

	// Oscillator enables; the running source cannot be switched off.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			osc_en_r <= csc_pkg::OSC_EN_RST;
		end else if (fail_det) begin
			osc_en_r <= osc_en_r | csc_pkg::OSC_EN_RST;
		end else if (we && addr == csc_pkg::A_OSC_EN) begin
			osc_en_r <= wdata[4:0] | (5'h01 << sys_src_r);
		end
	end

	// Failure monitor; detection beats a software clear.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			fail_en_r <= 1'b0;
			fail_flag_r <= 1'b0;
			nmi_r <= 1'b0;
		end else begin
			nmi_r <= fail_det;
			fail_flag_r <= fail_det | (fail_flag_r & ~(wr_fail & wdata[7]));
			if (wr_fail) begin
				fail_en_r <= wdata[0];
			end
		end
	end

	// Sleep setup, peripheral gating and the software reset unlock window.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			slp_r <= 4'h0;
			pr_r <= 8'h0;
			prot_cnt_r <= 3'h0;
		end else begin
			if (we && addr == csc_pkg::A_SLEEP) begin
				slp_r <= wdata[3:0];
			end
			if (we && addr == csc_pkg::A_PWR_RED) begin
				pr_r <= wdata;
			end
			if (we && addr == csc_pkg::A_PROTECT && wdata == csc_pkg::PROT_KEY) begin
				prot_cnt_r <= csc_pkg::PROT_WIN;
			end else if (prot_cnt_r != 3'h0) begin
				prot_cnt_r <= prot_cnt_r - 3'h1;
			end
		end
	end

	// Sleep sequence: enter on the instruction, leave on a wake source, hold four cycles.
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ST_RUN: if (sleep_instr && slp_r[0] && mode_ok(slp_r[3:1])) st_nxt = ST_SLEEP;
			ST_SLEEP: if (wake_ok(mode_r, wk_s2_r, rtc_en)) st_nxt = ST_WAKE;
			ST_WAKE: if (wcnt_r == csc_pkg::WAKE_HALT_LAST) st_nxt = ST_RUN;
		endcase
	end
	// On the entry edge the mode register still holds the last mode, so gating reads the setup.
	assign gate_mode = (st_r == ST_RUN) ? slp_r[3:1] : mode_r;
	assign gate_nxt = sleep_gate(st_nxt == ST_SLEEP, gate_mode, rtc_en);

	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			st_r <= ST_RUN;
			mode_r <= csc_pkg::SM_IDLE;
			wcnt_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			if (st_r == ST_RUN && st_nxt == ST_SLEEP) begin
				mode_r <= slp_r[3:1];
			end
			wcnt_r <= (st_r == ST_WAKE) ? wcnt_r + 2'h1 : 2'h0;
		end
	end

	// Clock enables and CPU handshake, all registered.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			gate_r <= '1;
			osc_run_r <= csc_pkg::OSC_EN_RST;
			cpu_halt_r <= 1'b0;
			resume_r <= 1'b0;
		end else begin
			gate_r <= gate_nxt;
			osc_run_r <= gate_nxt.osc ? (osc_en_r |
				{1'b0, cal_r[2] & |cal_r[1:0], ~cal_r[2] & |cal_r[1:0], 2'h0}) : 5'h0;
			cpu_halt_r <= st_nxt != ST_RUN;
			resume_r <= st_r == ST_WAKE && st_nxt == ST_RUN;
		end
	end

	// Per-peripheral clock gates: the domain gate masked by each power reduction bit.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_per
			always_ff @(posedge clk or negedge reset_out_b) begin
				if (!reset_out_b) begin
					per_clk_en_r[gi] <= 1'b1;
				end else begin
					per_clk_en_r[gi] <= gate_nxt.per & ~pr_r[gi];
				end
			end
		end
	endgenerate

	// Registered read port; unmapped offsets read zero.
	always_ff @(posedge clk or negedge reset_out_b) begin
		if (!reset_out_b) begin
			rdata <= 8'h0;
		end else if (re) begin
			unique case (addr)
				csc_pkg::A_CLK_SEL: rdata <= {2'h0, xosc_kind_r, 1'b0, sys_src_r};
				csc_pkg::A_PRESC: rdata <= {4'h0, presc_code_r};
				csc_pkg::A_PLL: rdata <= {1'b0, pll_in_r, pll_mult_r};
				csc_pkg::A_OSC_EN: rdata <= {3'h0, osc_en_r};
				csc_pkg::A_OSC_STAT: rdata <= {3'h0, rdy_s2_r};
				csc_pkg::A_FAIL: rdata <= {fail_flag_r, 6'h0, fail_en_r};
				csc_pkg::A_CAL: rdata <= {5'h0, cal_r};
				csc_pkg::A_SLEEP: rdata <= {4'h0, slp_r};
				csc_pkg::A_PWR_RED: rdata <= pr_r;
				csc_pkg::A_RST_STAT: rdata <= {2'h0, rstat_r};
				csc_pkg::A_RTC_SEL: rdata <= {6'h0, rtc_src_r};
				default: rdata <= 8'h0;
			endcase
		end
	end

	rst_src_a: assert property (@(posedge clk) disable iff (!rst_b)
		!reset_out_b |-> sys_src_r == csc_pkg::SRC_RC2M) else $error("source not 2M in reset");
	pll_range_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		pll_mult_r >= csc_pkg::PLL_MIN) else $error("multiplier out of range");
	presc_range_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		presc_code_r <= csc_pkg::PRESC_MAX) else $error("prescaler out of range");
	fail_nmi_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		fail_det |=> nmi_r && sys_src_r == csc_pkg::SRC_RC2M) else $error("no fallback on fail");
	no_ulp_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		sys_src_r <= csc_pkg::SRC_PLL) else $error("illegal system source");
	wake_halt_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		(st_r == ST_SLEEP && st_nxt == ST_WAKE) |=> cpu_halt_r [*4] ##1 (!cpu_halt_r && resume_r))
		else $error("wake halt not four cycles");
	idle_gate_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		(st_r == ST_SLEEP && mode_r == csc_pkg::SM_IDLE) |-> !gate_r.cpu && gate_r.osc)
		else $error("idle gating wrong");
	pdown_gate_a: assert property (@(posedge clk) disable iff (!reset_out_b)
		(st_r == ST_SLEEP && mode_r == csc_pkg::SM_PDOWN) |-> osc_run_r == 5'h0 && !gate_r.rtc)
		else $error("power-down left a clock on");
	hiz_rst_a: assert property (@(posedge clk) disable iff (!rst_b)
		!reset_out_b |-> io_hiz_r) else $error("pins driven in reset");
	rstat_sw_a: assert property (@(posedge clk) disable iff (!rst_b)
		sw_rst_r |=> rstat_r[5]) else $error("software reset not recorded");
endmodule // csc_ctrl
`default_nettype wire

// >>> csc_pkg.sv
// Constants, register map and carrier types for the clock, sleep and reset controller.
// Assumes an 8-bit register port and one 125 MHz system clock.
`default_nettype none
package csc_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	// Register offsets.
	localparam logic [3:0] A_CLK_SEL = 4'h0;
	localparam logic [3:0] A_PRESC = 4'h1;
	localparam logic [3:0] A_PLL = 4'h2;
	localparam logic [3:0] A_OSC_EN = 4'h3;
	localparam logic [3:0] A_OSC_STAT = 4'h4;
	localparam logic [3:0] A_FAIL = 4'h5;
	localparam logic [3:0] A_CAL = 4'h6;
	localparam logic [3:0] A_SLEEP = 4'h7;
	localparam logic [3:0] A_PWR_RED = 4'h8;
	localparam logic [3:0] A_RST_STAT = 4'h9;
	localparam logic [3:0] A_PROTECT = 4'ha;
	localparam logic [3:0] A_SW_RST = 4'hb;
	localparam logic [3:0] A_RTC_SEL = 4'hc;
	// System clock source codes, also the bit index in the oscillator enable mask.
	localparam logic [2:0] SRC_RC2M = 3'h0;
	localparam logic [2:0] SRC_RC32M = 3'h1;
	localparam logic [2:0] SRC_RC32K = 3'h2;
	localparam logic [2:0] SRC_XOSC = 3'h3;
	localparam logic [2:0] SRC_PLL = 3'h4;
	localparam int unsigned NOSC = 5;
	// Multiplier input codes and limits.
	localparam logic [1:0] PLL_IN_RC2M = 2'h0;
	localparam logic [1:0] PLL_IN_RC32M = 2'h1;
	localparam logic [1:0] PLL_IN_XOSC = 2'h2;
	localparam logic [4:0] PLL_MIN = 5'h01;
	localparam logic [4:0] PLL_MAX = 5'h1f;
	// Prescaler code n divides by two to the n, up to 2048.
	localparam logic [3:0] PRESC_MAX = 4'hb;
	// Real-time counter clock codes.
	localparam logic [1:0] RTC_ULP = 2'h0;
	localparam logic [1:0] RTC_RC32K = 2'h1;
	localparam logic [1:0] RTC_XTAL32K = 2'h2;
	// Sleep mode codes.
	localparam logic [2:0] SM_IDLE = 3'h0;
	localparam logic [2:0] SM_PDOWN = 3'h2;
	localparam logic [2:0] SM_PSAVE = 3'h3;
	localparam logic [2:0] SM_STDBY = 3'h6;
	localparam logic [2:0] SM_ESTDBY = 3'h7;
	// Reset values and counts.
	localparam logic [4:0] OSC_EN_RST = 5'h01;
	localparam logic [3:0] PRESC_RST = 4'h0;
	localparam logic [4:0] PLL_RST = 5'h01;
	localparam logic [1:0] WAKE_HALT_LAST = 2'h3;
	localparam logic [7:0] PROT_KEY = 8'hd8;
	localparam logic [2:0] PROT_WIN = 3'h4;
	localparam logic [5:0] RSTAT_POR = 6'h01;
	// Clock enables of one sleep state.
	typedef struct packed {
		logic cpu;
		logic nvm;
		logic per;
		logic rtc;
		logic osc;
	} csc_gate_t;
	// Wake-up requests.
	typedef struct packed {
		logic port_async;
		logic twi_match;
		logic rtc_irq;
		logic irq_any;
	} csc_wake_t;
	// Reset causes, bit 0 is power-on.
	typedef struct packed {
		logic sw;
		logic program_debug_interface;
		logic bod;
		logic wdt;
		logic ext;
		logic por;
	} csc_rcause_t;
endpackage
`default_nettype wire

// >>> csc_far_model.sv
// Far-side model of the oscillator bank that feeds the clock controller.
// Assumes one system clock; ready levels rise two cycles after run enables and drop at once.
`default_nettype none
module csc_far_model (
	input wire logic clk, // System clock.
	input wire logic rst_b, // Power-on reset, active low.
	input wire logic [4:0] osc_run, // Run enables from the controller.
	input wire logic fail_cmd, // Bench order to stop the crystal.
	output logic [4:0] osc_ready, // Ready levels per source.
	output logic xosc_ok // Crystal running level.
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] warm1_r;
	logic [4:0] warm2_r;
	// An oscillator needs two cycles to warm up before it reports ready.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			warm1_r <= 5'h00;
			warm2_r <= 5'h00;
		end else begin
			warm1_r <= osc_run;
			warm2_r <= warm1_r & osc_run;
		end
	end
	// A stopped or failed oscillator drops ready at once, so no stale level lingers.
	assign osc_ready = warm2_r & osc_run & ~{1'h0, fail_cmd, 3'h0};
	assign xosc_ok = osc_ready[3];
endmodule // csc_far_model
`default_nettype wire

// >>> test_csc_ctrl.sv
// Self-checking bench for the clock, sleep and reset controller.
// Assumes csc_pkg, csc_ctrl and csc_far_model are compiled before it.
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
`define WAITC(c) for (int w = 0; w < 40 && !(c); w++) begin @(posedge clk); #1; end
module test_csc_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [16:0] BOOT = 17'h10000;
	logic clk, rst_b, ext_rst_pin_b, wdt_rst, bod_rst, pdi_rst, we, re, xosc_ok, fail_cmd;
	logic rtc_en, sleep_instr, boot_fuse, nmi_r, cpu_halt_r, resume_r, io_hiz_r, reset_out_b;
	logic [3:0] addr, presc_code_r;
	logic [7:0] wdata, rdata, per_clk_en_r;
	logic [4:0] osc_ready, pll_mult_r, osc_run_r;
	logic [2:0] sys_src_r, cal_r;
	logic [1:0] pll_in_r, xosc_kind_r, rtc_src_r;
	logic [16:0] reset_vec_r;
	csc_pkg::csc_wake_t wake_in;
	csc_pkg::csc_gate_t gate_r;
	int failures = 0;
	int checked = 0;
	csc_ctrl #(.BOOT_VEC(BOOT)) u_dut (.clk(clk), .rst_b(rst_b), .ext_rst_pin_b(ext_rst_pin_b),
		.wdt_rst(wdt_rst), .bod_rst(bod_rst), .pdi_rst(pdi_rst), .addr(addr), .wdata(wdata),
		.we(we), .re(re), .rdata(rdata), .osc_ready(osc_ready), .xosc_ok(xosc_ok),
		.wake_in(wake_in), .rtc_en(rtc_en), .sleep_instr(sleep_instr), .boot_fuse(boot_fuse),
		.sys_src_r(sys_src_r), .presc_code_r(presc_code_r), .pll_mult_r(pll_mult_r),
		.pll_in_r(pll_in_r), .xosc_kind_r(xosc_kind_r), .rtc_src_r(rtc_src_r),
		.osc_run_r(osc_run_r), .cal_r(cal_r), .nmi_r(nmi_r), .gate_r(gate_r),
		.per_clk_en_r(per_clk_en_r), .cpu_halt_r(cpu_halt_r), .resume_r(resume_r),
		.io_hiz_r(io_hiz_r), .reset_out_b(reset_out_b), .reset_vec_r(reset_vec_r));
	csc_far_model u_far (.clk(clk), .rst_b(rst_b), .osc_run(osc_run_r), .fail_cmd(fail_cmd),
		.osc_ready(osc_ready), .xosc_ok(xosc_ok));
	// Free-running system clock of 8 ns.
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// Prints the verdict and ends the run.
	task automatic wrap_up;
		if (failures == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One-cycle register write; the value is visible when the task returns.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'h1;
		@(posedge clk);
		we <= 1'h0;
		#1;
	endtask
	// One-cycle register read; data is taken in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		re <= 1'h1;
		@(posedge clk);
		re <= 1'h0;
		#1;
		d = rdata;
	endtask
	// Values right after power-on.
	task automatic t_por;
		logic [7:0] d;
		`CHK(sys_src_r, csc_pkg::SRC_RC2M)
		`CHK(gate_r, 5'h1f)
		`CHK(per_clk_en_r, 8'hff)
		`CHK(reset_vec_r, 17'h00000)
		rd(csc_pkg::A_RST_STAT, d);
		`CHK(d, 8'h01)
	endtask
	// Prescaler, multiplier, counter clock, trim and gating registers at their limits.
	task automatic t_regs;
		logic [7:0] d;
		wr(csc_pkg::A_PRESC, 8'h0b);
		`CHK(presc_code_r, 4'hb)
		wr(csc_pkg::A_PRESC, 8'h0c);
		rd(csc_pkg::A_PRESC, d);
		`CHK(d, 8'h0b)
		wr(csc_pkg::A_PLL, 8'h5f);
		`CHK(pll_mult_r, 5'h1f)
		`CHK(pll_in_r, csc_pkg::PLL_IN_XOSC)
		wr(csc_pkg::A_PLL, 8'h20);
		`CHK(pll_mult_r, 5'h1f)
		wr(csc_pkg::A_PLL, 8'h01);
		`CHK(pll_mult_r, 5'h01)
		for (int i = 0; i < 4; i++) begin
			wr(csc_pkg::A_RTC_SEL, 8'(i));
			`CHK(rtc_src_r, (i < 3) ? 2'(i) : 2'h2)
		end
		wr(csc_pkg::A_CAL, 8'h03);
		`CHK(cal_r, 3'h3)
		@(posedge clk);
		#1;
		`CHK(osc_run_r[2], 1'h1)
		wr(csc_pkg::A_PWR_RED, 8'ha5);
		@(posedge clk);
		#1;
		`CHK(per_clk_en_r, 8'h5a)
		rd(4'hd, d);
		`CHK(d, 8'h00)
		wr(csc_pkg::A_CLK_SEL, 8'h25);
		repeat (8) @(posedge clk);
		#1;
		`CHK(sys_src_r, csc_pkg::SRC_RC2M)
		`CHK(xosc_kind_r, 2'h2)
	endtask
	// Source switch after readiness, then crystal failure with fallback.
	task automatic t_switch;
		logic [7:0] d;
		wr(csc_pkg::A_OSC_EN, 8'h03);
		wr(csc_pkg::A_CLK_SEL, 8'h01);
		`WAITC(sys_src_r == csc_pkg::SRC_RC32M)
		`CHK(sys_src_r, csc_pkg::SRC_RC32M)
		wr(csc_pkg::A_OSC_EN, 8'h0a);
		wr(csc_pkg::A_CLK_SEL, 8'h03);
		`WAITC(sys_src_r == csc_pkg::SRC_XOSC)
		`CHK(sys_src_r, csc_pkg::SRC_XOSC)
		wr(csc_pkg::A_FAIL, 8'h01);
		@(posedge clk);
		fail_cmd <= 1'h1;
		`WAITC(nmi_r)
		`CHK(nmi_r, 1'h1)
		`CHK(sys_src_r, csc_pkg::SRC_RC2M)
		@(posedge clk);
		#1;
		`CHK(osc_run_r[0], 1'h1)
		rd(csc_pkg::A_FAIL, d);
		`CHK(d[7], 1'h1)
		fail_cmd <= 1'h0;
		wr(csc_pkg::A_FAIL, 8'h80);
		rd(csc_pkg::A_FAIL, d);
		`CHK(d, 8'h00)
		wr(csc_pkg::A_OSC_EN, 8'h04);
		wr(csc_pkg::A_CLK_SEL, 8'h02);
		`WAITC(sys_src_r == csc_pkg::SRC_RC32K)
		`CHK(sys_src_r, csc_pkg::SRC_RC32K)
	endtask
	// Every sleep mode: gates asleep, a refused wake source outside idle, four halt cycles on wake.
	task automatic t_sleep;
		logic [2:0] md [5] = '{csc_pkg::SM_IDLE, csc_pkg::SM_PDOWN, csc_pkg::SM_PSAVE,
			csc_pkg::SM_STDBY, csc_pkg::SM_ESTDBY};
		logic [4:0] ge [5] = '{5'h07, 5'h00, 5'h02, 5'h01, 5'h03};
		logic [3:0] wk [5] = '{4'h1, 4'h8, 4'h2, 4'h4, 4'h2};
		int n;
		@(posedge clk);
		rtc_en <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			wr(csc_pkg::A_SLEEP, (i < 5) ? {4'h0, md[i], 1'h1} : 8'h03);
			@(posedge clk);
			sleep_instr <= 1'h1;
			@(posedge clk);
			sleep_instr <= 1'h0;
			#1;
			`CHK(cpu_halt_r, i < 5)
			if (i < 5) begin
				`CHK(gate_r, ge[i])
				`CHK(per_clk_en_r, ge[i][2] ? 8'h5a : 8'h00)
				if (i > 0) begin
					@(posedge clk);
					wake_in <= csc_pkg::csc_wake_t'(4'h1);
					repeat (8) @(posedge clk);
					#1;
					`CHK(cpu_halt_r, 1'h1)
				end
				@(posedge clk);
				wake_in <= csc_pkg::csc_wake_t'(wk[i]);
				n = 0;
				for (int w = 0; w < 20 && !resume_r; w++) begin
					@(posedge clk);
					#1;
					if (cpu_halt_r && gate_r == 5'h1f) n++;
				end
				`CHK(n, 4)
				`CHK(resume_r, 1'h1)
				`CHK(cpu_halt_r, 1'h0)
				@(posedge clk);
				wake_in <= csc_pkg::csc_wake_t'(4'h0);
			end
		end
		// Power-save with the counter off: its interrupt is refused, a port wake still works.
		@(posedge clk);
		rtc_en <= 1'h0;
		wr(csc_pkg::A_SLEEP, {4'h0, csc_pkg::SM_PSAVE, 1'h1});
		@(posedge clk);
		sleep_instr <= 1'h1;
		@(posedge clk);
		sleep_instr <= 1'h0;
		wake_in <= csc_pkg::csc_wake_t'(4'h2);
		repeat (8) @(posedge clk);
		#1;
		`CHK(gate_r, 5'h00)
		`CHK(cpu_halt_r, 1'h1)
		@(posedge clk);
		wake_in <= csc_pkg::csc_wake_t'(4'h8);
		`WAITC(resume_r)
		`CHK(resume_r, 1'h1)
		@(posedge clk);
		wake_in <= csc_pkg::csc_wake_t'(4'h0);
	endtask
	// Each pin reset source acts without a clock edge, software reset after its write; each restores registers and is recorded.
	task automatic t_resets;
		logic [7:0] d;
		for (int k = 1; k <= 5; k++) begin
			wr(csc_pkg::A_PRESC, 8'h05);
			wr(csc_pkg::A_RST_STAT, 8'h3f);
			boot_fuse <= (k == 5);
			if (k == 5) begin
				wr(csc_pkg::A_PROTECT, csc_pkg::PROT_KEY);
				wr(csc_pkg::A_SW_RST, 8'h01);
				`WAITC(!reset_out_b)
			end else begin
				@(posedge clk);
				ext_rst_pin_b <= (k != 1);
				wdt_rst <= (k == 2);
				bod_rst <= (k == 3);
				pdi_rst <= (k == 4);
				#1;
			end
			`CHK(reset_out_b, 1'h0)
			`CHK(io_hiz_r, 1'h1)
			`CHK(presc_code_r, csc_pkg::PRESC_RST)
			repeat (3) @(posedge clk);
			#1;
			`CHK(reset_out_b, k == 5)
			@(posedge clk);
			{wdt_rst, bod_rst, pdi_rst} <= 3'h0;
			ext_rst_pin_b <= 1'h1;
			`WAITC(reset_out_b)
			repeat (3) @(posedge clk);
			#1;
			`CHK(io_hiz_r, 1'h0)
			rd(csc_pkg::A_RST_STAT, d);
			`CHK(d, 8'h01 << k)
		end
		`CHK(reset_vec_r, BOOT)
	endtask
	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		wrap_up;
	end
	// Power-on reset for two cycles, then the scenarios in turn.
	initial begin
		rst_b = 1'h0;
		{ext_rst_pin_b, wdt_rst, bod_rst, pdi_rst} = 4'h8;
		{we, re, rtc_en, sleep_instr, boot_fuse, fail_cmd} = 6'h00;
		addr = 4'h0;
		wdata = 8'h00;
		wake_in = csc_pkg::csc_wake_t'(4'h0);
		repeat (2) @(posedge clk);
		rst_b <= 1'h1;
		`WAITC(reset_out_b)
		t_por;
		t_regs;
		t_switch;
		t_sleep;
		t_resets;
		wrap_up;
	end
endmodule // test_csc_ctrl
`default_nettype wire
